// file: design/ufcs_pkg.sv
// package for the uart flow control status block
package ufcs_pkg;
    localparam int ADDR_W = 8;
    localparam logic [7:0] ADDR_RECOG = 8'h40;
    localparam logic [7:0] ADDR_FLOW_STATUS = 8'h44;
    localparam logic [7:0] ADDR_MODE0 = 8'h48;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h49;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h4A;
    localparam logic [7:0] ADDR_ENABLES = 8'h4B;
    localparam logic [7:0] ADDR_CHARS = 8'h4C;
    localparam int MODE0_WDOG_BIT = 7;
    localparam int MODE0_AUTORX_BIT = 3;
    // placement of the transmit flow enable bit is our own choice
    localparam int MODE0_AUTOTX_BIT = 2;
    localparam int RE_WDOG_OFF = 7;
    localparam int RE_WDOG_ON = 6;
    localparam int RE_ADDR_OFF = 5;
    localparam int RE_ADDR_ON = 4;
    localparam int RE_XON_OFF = 3;
    localparam int RE_XON_ON = 2;
    localparam int RE_XOFF_OFF = 1;
    localparam int RE_XOFF_ON = 0;
    localparam logic [1:0] AUTO_NONE = 2'h0;
    localparam logic [1:0] AUTO_XON = 2'h1;
    localparam logic [1:0] AUTO_XOFF = 2'h2;
    localparam logic [1:0] FLOW_NORMAL = 2'h0;
    localparam logic [1:0] FLOW_PEND = 2'h1;
    localparam logic [1:0] FLOW_REEN = 2'h2;
    localparam logic [1:0] FLOW_HALT = 2'h3;
    localparam logic [1:0] TXC_DATA = 2'h0;
    localparam logic [1:0] TXC_IDLE = 2'h1;
    localparam logic [1:0] TXC_XOFF = 2'h2;
    localparam logic [1:0] TXC_XON = 2'h3;
    localparam int IRQ_XON = 0;
    localparam int IRQ_XOFF = 1;
    localparam int IRQ_ADDR = 2;
    localparam int IRQ_HALT = 3;
    localparam logic [7:0] RESET_ZERO = 8'h00;
    localparam logic [3:0] IRQ_USED = 4'hF;
    typedef struct packed {
        logic wdog;
        logic addr;
        logic xon;
        logic xoff;
    } ufcs_enables_t;
    typedef struct packed {
        logic [1:0] auto_char;
        logic [1:0] flow;
        logic [1:0] txc;
    } ufcs_status_t;
    typedef enum logic [1:0] {
        UFCS_RUN, UFCS_PEND, UFCS_HALT, UFCS_REEN
    } ufcs_flow_t;
endpackage

// file: design/ufcs_top.sv
// uart software flow control status and recognition enable logic
//
// Contract
// - auto field reports last flow char sent
// - auto field reads 00 unless auto mode
// - clearing auto mode bit resets auto field
// - flow field 00 during normal transmission
// - halt request: 01 then 11 after char
// - restart reads 10 until status read
// - flow field 11 while halted by xoff
// - char field 00 data, 01 idle wait
// - 10 xoff pending, 11 xon pending
// - enable and disable together means disable
// - recognition only reports, no flow action
// - bit7/6 watchdog strobes, zero no action
// - watchdog bit shared with mode bit 7; mode writes load it, but mode bit 7 reads back only the last mode write
// - bit4 enables, bit5 disables address recog
// - bits 2/3 xon, bits 0/1 xoff strobes
// - reading flow status clears upper bits
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/10ps
module ufcs_top
    import ufcs_pkg::*;
(
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    output logic irq,
    output logic watchdog_en,
    output logic addr_recog_en,
    output logic xon_recog_en,
    output logic xoff_recog_en,
    output logic auto_rx_mode,
    input wire logic rx_xon_seen,
    input wire logic rx_xoff_seen,
    input wire logic rx_addr_seen,
    input wire logic tx_char_done,
    input wire logic tx_bit_tick,
    input wire logic tx_fifo_empty,
    input wire logic send_xon_cmd,
    input wire logic send_xoff_cmd,
    input wire logic auto_xon_sent,
    input wire logic auto_xoff_sent,
    output logic tx_halted
);
    // enable flags, mode bits, status and interrupts
    ufcs_enables_t en;
    logic [7:0] mode0;
    logic [1:0] auto_char;
    logic [1:0] rx_char;
    logic [1:0] txc;
    ufcs_flow_t flow_st;
    logic [3:0] irq_stat;
    logic [3:0] irq_mask;
    logic idle_wait;
    logic [7:0] next_rdata;
    logic xoff_evt;
    logic xon_evt;

    function automatic logic strobe(input logic cur, input logic on,
                                    input logic off);
        // a simultaneous disable wins over enable
        if (off) begin
            return 1'b0;
        end
        if (on) begin
            return 1'b1;
        end
        return cur;
    endfunction

    wire wr_re = wr && (addr == ADDR_RECOG);
    wire wr_m0 = wr && (addr == ADDR_MODE0);
    wire rd_fs = rd && (addr == ADDR_FLOW_STATUS);
    wire auto_on = mode0[MODE0_AUTORX_BIT];
    // only the transmit flow mode bit lets a received flow char act;
    // the recognition enables merely report detections
    assign xoff_evt = rx_xoff_seen && mode0[MODE0_AUTOTX_BIT];
    assign xon_evt = rx_xon_seen && mode0[MODE0_AUTOTX_BIT];

    wire [1:0] flow_code = (flow_st == UFCS_PEND) ? FLOW_PEND :
                           (flow_st == UFCS_HALT) ? FLOW_HALT :
                           (flow_st == UFCS_REEN) ? FLOW_REEN :
                           FLOW_NORMAL;
    wire [1:0] auto_view = auto_on ? auto_char : AUTO_NONE;
    wire [7:0] fs_word = {rx_char, auto_view, flow_code, txc};

    wire [3:0] irq_set = {flow_st == UFCS_PEND && tx_char_done,
                          rx_addr_seen && en.addr,
                          rx_xoff_seen && en.xoff,
                          rx_xon_seen && en.xon};

    always_comb begin
        case (addr)
            ADDR_FLOW_STATUS: next_rdata = fs_word;
            ADDR_MODE0: next_rdata = mode0;
            ADDR_IRQ_STATUS: next_rdata = {4'h0, irq_stat};
            ADDR_IRQ_MASK: next_rdata = {4'h0, irq_mask};
            ADDR_ENABLES: next_rdata = {4'h0, en};
            default: next_rdata = RESET_ZERO; // write-only strobes read 0
        endcase
    end

    // recognition enables: set and cleared by strobes, held in en and read back at ADDR_ENABLES
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            en <= '0;
        end else if (wr_re) begin
            en.wdog <= strobe(en.wdog, wdata[RE_WDOG_ON],
                              wdata[RE_WDOG_OFF]);
            en.addr <= strobe(en.addr, wdata[RE_ADDR_ON],
                              wdata[RE_ADDR_OFF]);
            en.xon <= strobe(en.xon, wdata[RE_XON_ON],
                             wdata[RE_XON_OFF]);
            en.xoff <= strobe(en.xoff, wdata[RE_XOFF_ON],
                              wdata[RE_XOFF_OFF]);
        end else if (wr_m0) begin
            en.wdog <= wdata[MODE0_WDOG_BIT];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            mode0 <= RESET_ZERO;
        end else if (wr_m0) begin
            mode0 <= wdata;
        end
    end

    // auto flow character status
    always_ff @(posedge ref_clk) begin
        if (srst || !auto_on) begin
            auto_char <= AUTO_NONE;
        end else if (auto_xon_sent || auto_xoff_sent) begin
            auto_char <= {auto_xoff_sent, auto_xon_sent};
        end else if (rd_fs) begin
            auto_char <= AUTO_NONE;
        end
    end

    // received character status, set beats a read clear
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            rx_char <= 2'h0;
        end else begin
            rx_char <= (rd_fs ? 2'h0 : rx_char) |
                       {rx_xon_seen, rx_xoff_seen};
        end
    end

    // transmitter flow tracking
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            flow_st <= UFCS_RUN;
        end else begin
            case (flow_st)
                UFCS_RUN, UFCS_REEN: begin
                    if (xoff_evt) begin
                        flow_st <= UFCS_PEND;
                    end else if (flow_st == UFCS_REEN && rd_fs) begin
                        flow_st <= UFCS_RUN;
                    end
                end
                UFCS_PEND: begin
                    if (xon_evt) begin
                        flow_st <= UFCS_RUN;
                    end else if (tx_char_done) begin
                        flow_st <= UFCS_HALT;
                    end
                end
                UFCS_HALT: begin
                    if (xon_evt) begin
                        flow_st <= UFCS_REEN;
                    end
                end
                default: flow_st <= UFCS_RUN;
            endcase
        end
    end

    // transmit character status; a pending command clears on the next
    // tx_char_done and stays pending for as long as that pulse takes to arrive
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            txc <= TXC_DATA;
            idle_wait <= 1'b0;
        end else begin
            if (send_xon_cmd) begin
                txc <= TXC_XON;
            end else if (send_xoff_cmd) begin
                txc <= TXC_XOFF;
            end else if ((txc == TXC_XON || txc == TXC_XOFF)
                         && tx_char_done) begin
                txc <= TXC_IDLE;
                idle_wait <= 1'b1;
            end else if (txc == TXC_IDLE) begin
                if (idle_wait && tx_bit_tick) begin
                    idle_wait <= 1'b0;
                end
                if (!idle_wait && !tx_fifo_empty) begin
                    txc <= TXC_DATA;
                end
            end
        end
    end

    // interrupts: sticky, write one to clear, set wins
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            irq_stat <= 4'h0;
            irq_mask <= 4'h0;
        end else begin
            irq_stat <= (irq_stat &
                ~((wr && addr == ADDR_IRQ_STATUS) ? wdata[3:0] : 4'h0))
                | irq_set;
            if (wr && addr == ADDR_IRQ_MASK) begin
                irq_mask <= wdata[3:0] & IRQ_USED;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            rdata <= RESET_ZERO;
            irq <= 1'b0;
            watchdog_en <= 1'b0;
            addr_recog_en <= 1'b0;
            xon_recog_en <= 1'b0;
            xoff_recog_en <= 1'b0;
            auto_rx_mode <= 1'b0;
            tx_halted <= 1'b0;
        end else begin
            rdata <= rd ? next_rdata : RESET_ZERO;
            irq <= |(irq_stat & irq_mask);
            watchdog_en <= en.wdog;
            addr_recog_en <= en.addr;
            xon_recog_en <= en.xon;
            xoff_recog_en <= en.xoff;
            auto_rx_mode <= auto_on;
            tx_halted <= (flow_st == UFCS_HALT);
        end
    end
endmodule

// file: tb/ufcs_top_sva.sv
// assertion checker for the flow control status block
`timescale 1ns/10ps
module ufcs_chk
    import ufcs_pkg::*;
(
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] rdata,
    input wire logic watchdog_en,
    input wire logic addr_recog_en,
    input wire logic xon_recog_en,
    input wire logic xoff_recog_en,
    input wire logic auto_rx_mode,
    input wire logic tx_halted
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);
    wire wre = wr && addr == ADDR_RECOG;
    wire rfs = rd && addr == ADDR_FLOW_STATUS;
    property p_xon_on;
        wre && wdata[2] && !wdata[3] |-> ##2 xon_recog_en;
    endproperty
    a_xon_on: assert property (p_xon_on)
        else $error("xon flag not set");
    property p_xon_off;
        wre && wdata[3] |-> ##2 !xon_recog_en;
    endproperty
    a_xon_off: assert property (p_xon_off)
        else $error("xon flag kept");
    property p_xoff_on;
        wre && wdata[0] && !wdata[1] |-> ##2 xoff_recog_en;
    endproperty
    a_xoff_on: assert property (p_xoff_on)
        else $error("xoff flag not set");
    property p_addr_on;
        wre && wdata[4] && !wdata[5] |-> ##2 addr_recog_en;
    endproperty
    a_addr_on: assert property (p_addr_on)
        else $error("addr flag not set");
    property p_addr_off;
        wre && wdata[5] |-> ##2 !addr_recog_en;
    endproperty
    a_addr_off: assert property (p_addr_off)
        else $error("addr flag kept");
    property p_wdog_off;
        wre && wdata[7] |-> ##2 !watchdog_en;
    endproperty
    a_wdog_off: assert property (p_wdog_off)
        else $error("watchdog kept");
    property p_wdog_mode;
        wr && addr == ADDR_MODE0 |-> ##2 watchdog_en == $past(wdata[7], 2);
    endproperty
    a_wdog_mode: assert property (p_wdog_mode)
        else $error("mode watchdog bit");
    property p_auto_zero;
        !auto_rx_mode [*2] ##0 rfs |=> rdata[5:4] == 2'h0;
    endproperty
    a_auto_zero: assert property (p_auto_zero)
        else $error("auto field set");
    property p_halt_rd;
        rfs && tx_halted && $past(tx_halted) |=> rdata[3:2] == 2'h3;
    endproperty
    a_halt_rd: assert property (p_halt_rd)
        else $error("halt code wrong");
    property p_wo;
        rd && addr == ADDR_RECOG |=> rdata == 8'h00;
    endproperty
    a_wo: assert property (p_wo)
        else $error("strobe reg readable");
endmodule
bind ufcs_top ufcs_chk u_chk (.ref_clk, .srst, .addr, .wdata, .wr, .rd,
    .rdata,
    .watchdog_en, .addr_recog_en, .xon_recog_en, .xoff_recog_en,
    .auto_rx_mode, .tx_halted);

// file: tb/ufcs_remote.sv
// remote uart model: received flow chars and transmitter timing
`timescale 1ns/10ps
module ufcs_remote (
    input wire logic ref_clk,
    output logic rx_xon_seen,
    output logic rx_xoff_seen,
    output logic rx_addr_seen,
    output logic tx_bit_tick,
    output logic tx_char_done
);
    initial {rx_xon_seen, rx_xoff_seen, rx_addr_seen} = 3'h0;
    initial {tx_bit_tick, tx_char_done} = 2'h0;
    // k = {addr, xon, xoff}: one compare pulse per received char
    task automatic pulse_rx(input logic [2:0] k);
        @(posedge ref_clk);
        {rx_addr_seen, rx_xon_seen, rx_xoff_seen} <= k;
        @(posedge ref_clk);
        {rx_addr_seen, rx_xon_seen, rx_xoff_seen} <= 3'h0;
    endtask
    // ten bit times, then the character is done
    task automatic tx_char;
        repeat (10) begin
            @(posedge ref_clk);
            tx_bit_tick <= 1'b1;
            @(posedge ref_clk);
            tx_bit_tick <= 1'b0;
        end
        tx_char_done <= 1'b1;
        @(posedge ref_clk);
        tx_char_done <= 1'b0;
    endtask
endmodule

// file: tb/ufcs_top_tb.sv
// testbench for the flow control status block
`timescale 1ns/10ps
module ufcs_top_tb;
    logic ref_clk = 0;
    logic srst = 1;
    logic wr = 0;
    logic rd = 0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic [7:0] rdata;
    logic tx_fifo_empty = 0;
    logic send_xon_cmd = 0, send_xoff_cmd = 0;
    logic auto_xon_sent = 0, auto_xoff_sent = 0;
    logic irq, watchdog_en, addr_recog_en, xon_recog_en, xoff_recog_en;
    logic auto_rx_mode, tx_halted;
    logic rx_xon_seen, rx_xoff_seen, rx_addr_seen, tx_bit_tick, tx_char_done;
    int fail_count = 0;
    int n_checks = 0;
    logic [7:0] sv[7] = '{8'h55, 8'h00, 8'h88, 8'hC3, 8'h30, 8'h44, 8'h05};
    logic [7:0] se[7] = '{8'h0F, 8'h0F, 8'h05, 8'h04, 8'h00, 8'h0A, 8'h0B};
    always #25 ref_clk = ~ref_clk;
    ufcs_top u_dut (.ref_clk, .srst, .addr, .wdata, .wr, .rd, .rdata, .irq,
        .watchdog_en, .addr_recog_en, .xon_recog_en, .xoff_recog_en,
        .auto_rx_mode, .rx_xon_seen, .rx_xoff_seen, .rx_addr_seen,
        .tx_char_done, .tx_bit_tick, .tx_fifo_empty, .send_xon_cmd,
        .send_xoff_cmd, .auto_xon_sent, .auto_xoff_sent, .tx_halted);
    ufcs_remote u_rem (.ref_clk, .rx_xon_seen, .rx_xoff_seen,
        .rx_addr_seen, .tx_bit_tick, .tx_char_done);
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge ref_clk);
        wr <= 1'b0;
    endtask
    // compare only the bits under m
    task automatic rchk(input logic [7:0] a, input logic [7:0] e,
                        input logic [7:0] m);
        @(posedge ref_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge ref_clk);
        rd <= 1'b0;
        #1 cmp(rdata & m, e);
    endtask
    // v = {send xon, send xoff, auto xon sent, auto xoff sent}
    task automatic pulse(input logic [3:0] v);
        @(posedge ref_clk);
        {send_xon_cmd, send_xoff_cmd, auto_xon_sent, auto_xoff_sent} <= v;
        @(posedge ref_clk);
        {send_xon_cmd, send_xoff_cmd, auto_xon_sent, auto_xoff_sent} <= 4'h0;
    endtask
    task automatic end_sim;
        if (fail_count == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial begin
        #200000;
        fail_count++;
        end_sim();
    end
    initial begin
        repeat (4) @(posedge ref_clk);
        srst <= 1'b0;
        rchk(8'h44, 8'h00, 8'hFF);
        rchk(8'h40, 8'h00, 8'hFF);
        rchk(8'h50, 8'h00, 8'hFF);
        for (int i = 0; i < 7; i++) begin
            wreg(8'h40, sv[i]);
            rchk(8'h4B, se[i], 8'h0F);
        end
        wreg(8'h48, 8'h00);
        rchk(8'h4B, 8'h03, 8'h0F);
        wreg(8'h48, 8'h84);
        rchk(8'h4B, 8'h0B, 8'h0F);
        wreg(8'h4A, 8'h00);
        u_rem.pulse_rx(3'h1);
        rchk(8'h44, 8'h44, 8'hFC);
        u_rem.tx_char();
        rchk(8'h44, 8'h0C, 8'hFC);
        cmp({7'h00, tx_halted}, 8'h01);
        rchk(8'h49, 8'h0A, 8'h0A);
        cmp({7'h00, irq}, 8'h00);
        wreg(8'h4A, 8'h0A);
        repeat (2) @(posedge ref_clk);
        #1 cmp({7'h00, irq}, 8'h01);
        wreg(8'h49, 8'h0A);
        repeat (2) @(posedge ref_clk);
        #1 cmp({7'h00, irq}, 8'h00);
        u_rem.pulse_rx(3'h2);
        rchk(8'h44, 8'h88, 8'hFC);
        rchk(8'h44, 8'h00, 8'hFC);
        pulse(4'h4);
        rchk(8'h44, 8'h02, 8'h03);
        u_rem.tx_char();
        rchk(8'h44, 8'h01, 8'h03);
        pulse(4'h8);
        rchk(8'h44, 8'h03, 8'h03);
        u_rem.tx_char();
        pulse(4'h2);
        rchk(8'h44, 8'h00, 8'h30);
        wreg(8'h48, 8'h88);
        pulse(4'h2);
        rchk(8'h44, 8'h10, 8'h30);
        pulse(4'h1);
        wreg(8'h48, 8'h80);
        rchk(8'h44, 8'h00, 8'h30);
        // host owes the xon once auto mode is left after an xoff
        pulse(4'h8);
        u_rem.tx_char();
        end_sim();
    end
endmodule
